// file: core/ocdt_top.sv
/*
 One-count delay and one-shot pulse timer with master and slave channel,
 prescaler, pin trigger conditioning and AHB-Lite register slave.
 Assumes one 40 MHz hclk and a trigger pin asynchronous to it.
*/
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ocdt_top #(
    parameter int unsigned W = ocdt_pkg::DATA_W
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        trigger_input_pin,
    output logic             slave_pulse_pin,
    output logic             master_expiry_irq,
    output logic             slave_expiry_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        addr_ok;
    logic        wr_en;
    logic [31:0] rd_mux;

    // Registers
    logic            unit_power_enable, unit_power_enable_next;
    logic [15:0]     prescale_select_reg, prescale_select_next;
    logic [1:0]      input_filter_enable_reg, input_filter_enable_next;
    logic [15:0]     mode_m_reg, mode_m_next;
    logic [15:0]     mode_s_reg, mode_s_next;
    logic [W-1:0]    master_reload_value, master_reload_next;
    logic [W-1:0]    slave_reload_value, slave_reload_next;
    logic [3:0]      outctl_reg, outctl_next;
    logic            upper_half_running_flag, upper_half_next;
    logic            channel_go_bit, slave_go_bit, upper_half_go_bit;
    logic            channel_halt_bit, slave_halt_bit, upper_half_halt_bit;
    logic            clear;

    // Channel side
    logic [W-1:0]    master_down_counter, slave_down_counter;
    logic            channel_running_flag, slave_running_flag;
    logic            m_irq, s_irq, s_active;
    logic [3:0]      tick_vec;
    logic            m_tick, s_tick;
    logic            m_trig, s_trig;
    logic            pin_edge;

    assign addr_ok = hsel & hready & (htrans == ocdt_pkg::HTRANS_NSEQ
                     || htrans == ocdt_pkg::HTRANS_SEQ);
    assign wr_en   = wr_pend_reg & unit_power_enable;

    always_comb begin
        case (haddr[7:0])
            ocdt_pkg::OFS_PERIPH: rd_mux = {31'h0000_0000, unit_power_enable};
            ocdt_pkg::OFS_PRESCL: rd_mux = {16'h0000, prescale_select_reg};
            ocdt_pkg::OFS_FILTER: rd_mux = {30'h0000_0000, input_filter_enable_reg};
            ocdt_pkg::OFS_MODE_M: rd_mux = {16'h0000, mode_m_reg};
            ocdt_pkg::OFS_MODE_S: rd_mux = {16'h0000, mode_s_reg};
            ocdt_pkg::OFS_RELD_M: rd_mux = 32'(master_reload_value);
            ocdt_pkg::OFS_RELD_S: rd_mux = 32'(slave_reload_value);
            ocdt_pkg::OFS_CNT_M:  rd_mux = 32'(master_down_counter);
            ocdt_pkg::OFS_CNT_S:  rd_mux = 32'(slave_down_counter);
            ocdt_pkg::OFS_RUN:    rd_mux = {29'h0000_0000, upper_half_running_flag,
                                            slave_running_flag, channel_running_flag};
            ocdt_pkg::OFS_OUTCTL: rd_mux = {28'h0000_000, outctl_reg};
            default:              rd_mux = ocdt_pkg::RD_ZERO;
        endcase
    end

    always_comb begin
        wr_pend_next = addr_ok & hwrite;
        wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
        rdata_next   = (addr_ok && !hwrite) ? rd_mux : ocdt_pkg::RD_ZERO;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= ocdt_pkg::RD_ZERO;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = ocdt_pkg::HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    assign clear = ~unit_power_enable;

    // Trigger bits exist only for the write cycle, so they read back zero
    always_comb begin
        channel_go_bit      = wr_en && wr_addr_reg == ocdt_pkg::OFS_GO
                              && hwdata[ocdt_pkg::BIT_MASTER];
        slave_go_bit        = wr_en && wr_addr_reg == ocdt_pkg::OFS_GO
                              && hwdata[ocdt_pkg::BIT_SLAVE];
        upper_half_go_bit   = wr_en && wr_addr_reg == ocdt_pkg::OFS_GO
                              && hwdata[ocdt_pkg::BIT_UPPER];
        channel_halt_bit    = wr_en && wr_addr_reg == ocdt_pkg::OFS_HALT
                              && hwdata[ocdt_pkg::BIT_MASTER];
        slave_halt_bit      = wr_en && wr_addr_reg == ocdt_pkg::OFS_HALT
                              && hwdata[ocdt_pkg::BIT_SLAVE];
        upper_half_halt_bit = wr_en && wr_addr_reg == ocdt_pkg::OFS_HALT
                              && hwdata[ocdt_pkg::BIT_UPPER];
    end

    always_comb begin
        unit_power_enable_next   = unit_power_enable;
        prescale_select_next     = prescale_select_reg;
        input_filter_enable_next = input_filter_enable_reg;
        mode_m_next              = mode_m_reg;
        mode_s_next              = mode_s_reg;
        master_reload_next       = master_reload_value;
        slave_reload_next        = slave_reload_value;
        outctl_next              = outctl_reg;
        upper_half_next          = upper_half_running_flag;
        if (wr_pend_reg && wr_addr_reg == ocdt_pkg::OFS_PERIPH) begin
            unit_power_enable_next = hwdata[0];
        end
        if (wr_en) begin
            case (wr_addr_reg)
                ocdt_pkg::OFS_PRESCL: prescale_select_next     = hwdata[15:0];
                ocdt_pkg::OFS_FILTER: input_filter_enable_next = hwdata[1:0];
                ocdt_pkg::OFS_MODE_M: mode_m_next              = hwdata[15:0];
                ocdt_pkg::OFS_MODE_S: mode_s_next              = hwdata[15:0];
                ocdt_pkg::OFS_RELD_M: master_reload_next       = hwdata[W-1:0];
                ocdt_pkg::OFS_RELD_S: slave_reload_next        = hwdata[W-1:0];
                ocdt_pkg::OFS_OUTCTL: outctl_next              = hwdata[3:0];
                default: begin
                end
            endcase
        end
        if (upper_half_go_bit) begin
            upper_half_next = 1'b1;
        end
        if (upper_half_halt_bit) begin
            upper_half_next = 1'b0;
        end
        if (clear) begin
            prescale_select_next     = ocdt_pkg::PRESCL_RST;
            input_filter_enable_next = 2'h0;
            mode_m_next              = ocdt_pkg::MODE_RST;
            mode_s_next              = ocdt_pkg::MODE_RST;
            master_reload_next       = W'(ocdt_pkg::RELD_RST);
            slave_reload_next        = W'(ocdt_pkg::RELD_RST);
            outctl_next              = 4'h0;
            upper_half_next          = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_power_enable       <= 1'b0;
            prescale_select_reg     <= ocdt_pkg::PRESCL_RST;
            input_filter_enable_reg <= 2'h0;
            mode_m_reg              <= ocdt_pkg::MODE_RST;
            mode_s_reg              <= ocdt_pkg::MODE_RST;
            master_reload_value     <= W'(ocdt_pkg::RELD_RST);
            slave_reload_value      <= W'(ocdt_pkg::RELD_RST);
            outctl_reg              <= 4'h0;
            upper_half_running_flag <= 1'b0;
        end else begin
            unit_power_enable       <= unit_power_enable_next;
            prescale_select_reg     <= prescale_select_next;
            input_filter_enable_reg <= input_filter_enable_next;
            mode_m_reg              <= mode_m_next;
            mode_s_reg              <= mode_s_next;
            master_reload_value     <= master_reload_next;
            slave_reload_value      <= slave_reload_next;
            outctl_reg              <= outctl_next;
            upper_half_running_flag <= upper_half_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: tick k when the low N bits of the divider are all ones
    logic [ocdt_pkg::PRE_W-1:0] div_reg, div_next;

    always_comb begin
        div_next = clear ? '0 : div_reg + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    for (genvar k = 0; k < 4; k++) begin : g_pre
        logic [ocdt_pkg::PRE_W-1:0] mask;
        assign mask = ~({ocdt_pkg::PRE_W{1'b1}} << prescale_select_reg[4*k +: 4]);
        assign tick_vec[k] = ~clear & ((div_reg & mask) == mask);
    end

    assign m_tick = tick_vec[mode_m_reg[ocdt_pkg::CKS_LSB +: 2]];
    assign s_tick = tick_vec[mode_s_reg[ocdt_pkg::CKS_LSB +: 2]];

    ////////////////////////////////////////////////////////////////////////////
    // Trigger pin: sync, optional filter, edge detect
    logic       sync1_reg, sync2_reg, filt_reg, filt_next, prev_reg;
    logic [1:0] cis;

    assign cis = mode_m_reg[ocdt_pkg::CIS_LSB +: 2];

    always_comb begin
        filt_next = filt_reg;
        if (!input_filter_enable_reg[0] || sync2_reg == prev_reg) begin
            filt_next = sync2_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            filt_reg  <= 1'b0;
        end else begin
            sync1_reg <= trigger_input_pin;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    always_comb begin
        case (cis)
            ocdt_pkg::CIS_FALL: pin_edge = ~filt_next & filt_reg;
            ocdt_pkg::CIS_RISE: pin_edge = filt_next & ~filt_reg;
            default:            pin_edge = filt_next ^ filt_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    assign m_trig = mode_m_reg[ocdt_pkg::STS_LSB +: 3] == ocdt_pkg::STS_PIN
                    && pin_edge;
    assign s_trig = (mode_s_reg[ocdt_pkg::STS_LSB +: 3] == ocdt_pkg::STS_MASTER
                     && m_irq)
                    || (mode_s_reg[ocdt_pkg::STS_LSB +: 3] == ocdt_pkg::STS_PIN
                     && pin_edge);

    ocdt_channel #(.W(W)) u_master (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .clear        (clear),
        .count_tick   (m_tick),
        .go_pulse     (channel_go_bit),
        .halt_pulse   (channel_halt_bit),
        .trig_pulse   (m_trig),
        .retrig_ok    (mode_m_reg[ocdt_pkg::RETRIG_BIT]),
        .mode_ok      (mode_m_reg[ocdt_pkg::MD_LSB +: 3] == ocdt_pkg::MD_ONE_COUNT),
        .reload_value (master_reload_value),
        .down_counter (master_down_counter),
        .running_flag (channel_running_flag),
        .expiry_irq   (m_irq),
        .active       ()
    );

    ocdt_channel #(.W(W)) u_slave (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .clear        (clear),
        .count_tick   (s_tick),
        .go_pulse     (slave_go_bit),
        .halt_pulse   (slave_halt_bit),
        .trig_pulse   (s_trig),
        .retrig_ok    (mode_s_reg[ocdt_pkg::RETRIG_BIT]),
        .mode_ok      (mode_s_reg[ocdt_pkg::MD_LSB +: 3] == ocdt_pkg::MD_ONE_COUNT),
        .reload_value (slave_reload_value),
        .down_counter (slave_down_counter),
        .running_flag (slave_running_flag),
        .expiry_irq   (s_irq),
        .active       (s_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Slave pulse output
    logic pin_reg, pin_next;

    always_comb begin
        pin_next = outctl_reg[ocdt_pkg::BIT_POL] ^ (outctl_reg[ocdt_pkg::BIT_DRIVE]
                   & outctl_reg[ocdt_pkg::BIT_FOLLOW] & s_active);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign slave_pulse_pin   = pin_reg;
    assign master_expiry_irq = m_irq;
    assign slave_expiry_irq  = s_irq;
endmodule // ocdt_top

// file: shared/ocdt_pkg.sv
/*
 Constants, register map and channel state type for the one-count delay and
 one-shot timer. Assumes a 32-bit AHB-Lite bus and a single system clock.
*/
package ocdt_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned PRE_W      = 16;
    // Byte offsets
    localparam logic [7:0] OFS_PERIPH  = 8'h00;
    localparam logic [7:0] OFS_PRESCL  = 8'h04;
    localparam logic [7:0] OFS_FILTER  = 8'h08;
    localparam logic [7:0] OFS_MODE_M  = 8'h0c;
    localparam logic [7:0] OFS_MODE_S  = 8'h10;
    localparam logic [7:0] OFS_RELD_M  = 8'h14;
    localparam logic [7:0] OFS_RELD_S  = 8'h18;
    localparam logic [7:0] OFS_CNT_M   = 8'h1c;
    localparam logic [7:0] OFS_CNT_S   = 8'h20;
    localparam logic [7:0] OFS_GO      = 8'h24;
    localparam logic [7:0] OFS_HALT    = 8'h28;
    localparam logic [7:0] OFS_RUN     = 8'h2c;
    localparam logic [7:0] OFS_OUTCTL  = 8'h30;
    localparam logic [7:0] OFS_STATUS  = 8'h34;
    // Bit positions in go, halt and running registers
    localparam int unsigned BIT_MASTER = 0;
    localparam int unsigned BIT_SLAVE  = 1;
    localparam int unsigned BIT_UPPER  = 2;
    // Output control bits
    localparam int unsigned BIT_DRIVE  = 0;
    localparam int unsigned BIT_POL    = 1;
    localparam int unsigned BIT_FOLLOW = 2;
    // Mode register fields
    localparam int unsigned CKS_LSB    = 14;
    localparam int unsigned CCS_BIT    = 12;
    localparam int unsigned LEAD_BIT   = 11;
    localparam int unsigned STS_LSB    = 8;
    localparam int unsigned CIS_LSB    = 6;
    localparam int unsigned MD_LSB     = 1;
    localparam int unsigned RETRIG_BIT = 0;
    localparam logic [2:0] MD_ONE_COUNT = 3'h4;
    localparam logic [2:0] STS_SOFT     = 3'h0;
    localparam logic [2:0] STS_PIN      = 3'h1;
    localparam logic [2:0] STS_MASTER   = 3'h4;
    localparam logic [1:0] CIS_FALL     = 2'h0;
    localparam logic [1:0] CIS_RISE     = 2'h1;
    // Reset values
    localparam logic [15:0] MODE_RST    = 16'h0000;
    localparam logic [15:0] RELD_RST    = 16'h0000;
    localparam logic [15:0] PRESCL_RST  = 16'h0000;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
    // AHB encodings
    localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
    localparam logic [1:0] HTRANS_SEQ   = 2'h3;
    localparam logic [2:0] HSIZE_WORD   = 3'h2;
    localparam logic       HRESP_OKAY   = 1'b0;

    typedef enum logic [1:0] {CH_IDLE, CH_LOAD, CH_COUNT} ocdt_ch_state_e;
endpackage

// file: core/ocdt_channel.sv
/*
 One timer channel in one-count mode: load on start trigger, count down on
 count ticks, one-cycle expiry pulse at zero. Assumes ticks and triggers are
 single-cycle pulses in the hclk domain.
*/
`timescale 1ns/1ps
module ocdt_channel #(
    parameter int unsigned W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         clear,
    input  wire logic         count_tick,
    input  wire logic         go_pulse,
    input  wire logic         halt_pulse,
    input  wire logic         trig_pulse,
    input  wire logic         retrig_ok,
    input  wire logic         mode_ok,
    input  wire logic [W-1:0] reload_value,
    output logic      [W-1:0] down_counter,
    output logic              running_flag,
    output logic              expiry_irq,
    output logic              active
);
    ocdt_pkg::ocdt_ch_state_e state_reg, state_next;
    logic [W-1:0] cnt_reg, cnt_next;
    logic         run_reg, run_next;
    logic         irq_reg, irq_next;
    logic         start_evt;

    // Software go while running is itself a start trigger
    assign start_evt = mode_ok & run_reg & (trig_pulse | go_pulse);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        run_next   = run_reg;
        irq_next   = 1'b0;
        case (state_reg)
            ocdt_pkg::CH_LOAD: begin
                if (count_tick) begin
                    cnt_next = reload_value;
                    if (reload_value == '0) begin
                        irq_next   = 1'b1;
                        state_next = ocdt_pkg::CH_IDLE;
                    end else begin
                        state_next = ocdt_pkg::CH_COUNT;
                    end
                end
            end
            ocdt_pkg::CH_COUNT: begin
                if (count_tick) begin
                    cnt_next = cnt_reg - 1'b1;
                    if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                        irq_next   = 1'b1;
                        state_next = ocdt_pkg::CH_IDLE;
                    end
                end
            end
            default: begin
                state_next = ocdt_pkg::CH_IDLE;
            end
        endcase
        if (start_evt && (state_reg != ocdt_pkg::CH_COUNT || retrig_ok)) begin
            state_next = ocdt_pkg::CH_LOAD;
        end
        if (go_pulse) begin
            run_next = 1'b1;
        end
        if (halt_pulse) begin
            run_next   = 1'b0;
            state_next = ocdt_pkg::CH_IDLE;
            irq_next   = 1'b0;
        end
        if (!run_reg && !go_pulse) begin
            state_next = ocdt_pkg::CH_IDLE;
        end
        if (clear) begin
            state_next = ocdt_pkg::CH_IDLE;
            cnt_next   = '0;
            run_next   = 1'b0;
            irq_next   = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ocdt_pkg::CH_IDLE;
            cnt_reg   <= '0;
            run_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            run_reg   <= run_next;
            irq_reg   <= irq_next;
        end
    end

    assign down_counter = cnt_reg;
    assign running_flag = run_reg;
    assign expiry_irq   = irq_reg;
    assign active       = (state_reg == ocdt_pkg::CH_COUNT);
endmodule // ocdt_channel

// file: testbench/ocdt_properties.sv
/* Bus and pulse checks on the timer top ports.
   Assumes bind from the bench top, one clock. */
`timescale 1ns/1ps
module ocdt_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        trigger_input_pin,
    input wire logic        slave_pulse_pin,
    input wire logic        master_expiry_irq,
    input wire logic        slave_expiry_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_resp_okay: assert property (hresp == ocdt_pkg::HRESP_OKAY) else $error("bad resp");
    a_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite)
        |=> hrdata == 32'h0) else $error("stale read data");
    a_go_reads_zero: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr[7:0] == ocdt_pkg::OFS_GO |=> hrdata == 32'h0) else $error("go bit stuck");
    a_halt_reads_zero: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr[7:0] == ocdt_pkg::OFS_HALT |=> hrdata == 32'h0) else $error("halt stuck");
    a_status_unused: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr[7:0] == ocdt_pkg::OFS_STATUS |=> hrdata == 32'h0) else $error("status used");
    a_master_irq_pulse: assert property (master_expiry_irq |=> !master_expiry_irq)
        else $error("master irq long");
    a_slave_irq_pulse: assert property ($rose(slave_expiry_irq) |=> $fell(slave_expiry_irq))
        else $error("slave irq long");
endmodule // ocdt_chk

// file: testbench/ocdt_pin_model.sv
/* Trigger pin driver: one clean high pulse per fire request.
   Assumes fire is a one-cycle pulse from the bench. */
`timescale 1ns/1ps
module ocdt_pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire,
    output logic     trigger_input_pin
);
    int hold;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trigger_input_pin <= 1'b0;
            hold <= 0;
        end else if (fire) begin
            trigger_input_pin <= 1'b1;
            hold <= 6;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            trigger_input_pin <= 1'b0;
        end
    end
endmodule // ocdt_pin_model

// file: testbench/one_count_delay_and_one_shot_timer_tb_top.sv
/* Register-level bench of the timer over AHB-Lite.
   Assumes a zero-wait slave and prescale 0 ticking every hclk. */
`timescale 1ns/1ps
`define CHK(s, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", s, e, a); end end
module one_count_delay_and_one_shot_timer_tb_top;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, spin, mirq, sirq, fire, pol;
    logic [31:0] haddr, hwdata, hrdata, q, c;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          num_errors, cmp_count, n, m, r;
    ocdt_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_input_pin(pin),
        .slave_pulse_pin(spin), .master_expiry_irq(mirq), .slave_expiry_irq(sirq));
    ocdt_pin_model i_pin (.hclk(hclk), .hresetn(hresetn), .fire(fire), .trigger_input_pin(pin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ocdt_pkg::HTRANS_NSEQ;
        hwrite <= w;
        hsize <= ocdt_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_irq;
        n = 0;
        while (mirq !== 1'b1 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000) num_errors++;
    endtask
    task automatic complete_run;
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        complete_run();
    end
    initial begin
        {hsel, hwrite, fire, hresetn, haddr, hwdata, htrans, hsize} = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(ocdt_pkg::OFS_RELD_M, 1'b1, 32'h55);
        bus(ocdt_pkg::OFS_PERIPH, 1'b1, 32'h1);
        bus(ocdt_pkg::OFS_RELD_M, 1'b0, 32'h0);
        `CHK("reload_locked", 32'h0, q)
        bus(8'h80, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        bus(ocdt_pkg::OFS_FILTER, 1'b1, 32'h1);
        bus(ocdt_pkg::OFS_MODE_M, 1'b1, 32'h0808);
        bus(ocdt_pkg::OFS_MODE_S, 1'b1, 32'h0408);
        bus(ocdt_pkg::OFS_RELD_M, 1'b1, 32'h3);
        bus(ocdt_pkg::OFS_RELD_S, 1'b1, 32'h4);
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            bus(ocdt_pkg::OFS_HALT, 1'b1, 32'h3);
            bus(ocdt_pkg::OFS_OUTCTL, 1'b1, {29'h0, 1'b1, pol, 1'b1});
            bus(ocdt_pkg::OFS_GO, 1'b1, 32'h3);
            bus(ocdt_pkg::OFS_RUN, 1'b0, 32'h0);
            `CHK("both_running", 32'h3, q)
            `CHK("idle_level", pol, spin)
            bus(ocdt_pkg::OFS_GO, 1'b1, 32'h1);
            m = 0;
            for (int k = 0; k < 100 && m == 0; k++) @(posedge hclk) m = (spin === ~pol);
            while (spin === ~pol && m < 100) @(posedge hclk) m++;
            `CHK("pulse_width", 4, m - 1)
        end
        bus(ocdt_pkg::OFS_MODE_M, 1'b1, 32'h0008);
        for (int ps = 0; ps < 2; ps++) begin
            bus(ocdt_pkg::OFS_PRESCL, 1'b1, ps);
            // First run aligns the tick phase for the measured run
            for (int j = 0; j < 2; j++) begin
                bus(ocdt_pkg::OFS_RELD_M, 1'b1, 32'd3);
                bus(ocdt_pkg::OFS_GO, 1'b1, 32'h1);
                wait_irq();
            end
            r = n;
            bus(ocdt_pkg::OFS_RELD_M, 1'b1, 32'd10);
            bus(ocdt_pkg::OFS_GO, 1'b1, 32'h1);
            wait_irq();
            `CHK("delay_step", 7 << ps, n - r)
            bus(ocdt_pkg::OFS_CNT_M, 1'b0, 32'h0);
            `CHK("count_end", 32'h0, q)
        end
        bus(ocdt_pkg::OFS_MODE_M, 1'b1, 32'h0948);
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        wait_irq();
        `CHK("pin_trigger", 1'b1, mirq)
        bus(ocdt_pkg::OFS_MODE_M, 1'b1, 32'h0008);
        bus(ocdt_pkg::OFS_RELD_M, 1'b1, 32'h100);
        bus(ocdt_pkg::OFS_GO, 1'b1, 32'h1);
        repeat (10) @(posedge hclk);
        bus(ocdt_pkg::OFS_HALT, 1'b1, 32'h1);
        bus(ocdt_pkg::OFS_CNT_M, 1'b0, 32'h0);
        c = q;
        repeat (10) @(posedge hclk);
        bus(ocdt_pkg::OFS_CNT_M, 1'b0, 32'h0);
        `CHK("count_hold", c, q)
        bus(ocdt_pkg::OFS_RUN, 1'b0, 32'h0);
        `CHK("halted", 1'b0, q[0])
        bus(ocdt_pkg::OFS_GO, 1'b1, 32'h4);
        bus(ocdt_pkg::OFS_RUN, 1'b0, 32'h0);
        `CHK("upper_run", 1'b1, q[2])
        bus(ocdt_pkg::OFS_HALT, 1'b1, 32'h4);
        bus(ocdt_pkg::OFS_RUN, 1'b0, 32'h0);
        `CHK("upper_halt", 1'b0, q[2])
        bus(ocdt_pkg::OFS_GO, 1'b0, 32'h0);
        `CHK("go_reads_zero", 32'h0, q)
        bus(ocdt_pkg::OFS_HALT, 1'b0, 32'h0);
        `CHK("halt_reads_zero", 32'h0, q)
        bus(ocdt_pkg::OFS_STATUS, 1'b0, 32'h0);
        `CHK("status_unused", 32'h0, q)
        bus(ocdt_pkg::OFS_PERIPH, 1'b1, 32'h0);
        bus(ocdt_pkg::OFS_PERIPH, 1'b1, 32'h1);
        bus(ocdt_pkg::OFS_RELD_M, 1'b0, 32'h0);
        `CHK("reload_cleared", 32'h0, q)
        bus(ocdt_pkg::OFS_RUN, 1'b0, 32'h0);
        `CHK("run_cleared", 32'h0, q)
        complete_run();
    end
endmodule // one_count_delay_and_one_shot_timer_tb_top
bind ocdt_top ocdt_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_input_pin(trigger_input_pin),
    .slave_pulse_pin(slave_pulse_pin), .master_expiry_irq(master_expiry_irq),
    .slave_expiry_irq(slave_expiry_irq));
